/* hdl/slem_map.svh */
// Register map, field positions and reset values of the lane error monitor.
// ============================================================================
`ifndef SLEM_MAP_SVH
`define SLEM_MAP_SVH

// ============================================================================
// Register indexes and byte addresses
`define SLEM_IDX_ERRSEL    12'h46B
`define SLEM_IDX_DESKEW    12'h46C
`define SLEM_ADDR_ERRSEL   {18'h0, `SLEM_IDX_ERRSEL, 2'h0}
`define SLEM_ADDR_DESKEW   {18'h0, `SLEM_IDX_DESKEW, 2'h0}
`define SLEM_ADDR_IRQ_STAT 32'h0000_1200
`define SLEM_ADDR_IRQ_CLR  32'h0000_1204
`define SLEM_ADDR_IRQ_EN   32'h0000_1208
`define SLEM_ADDR_MODE     32'h0000_120C

// ============================================================================
// Field positions
`define SLEM_LANE_HI       6
`define SLEM_LANE_LO       4
`define SLEM_KIND_HI       1
`define SLEM_KIND_LO       0
`define SLEM_MODE_DUAL     0

// ============================================================================
// Reset values and the counter saturation value
`define SLEM_DESKEW_RST    8'h0F
`define SLEM_CNT_FULL      8'hFF

`endif

/* hdl/slem_pkg.sv */
// Types shared by the lane error monitor register logic.
package slem_pkg;

  typedef enum logic [1:0] {
    SLEM_KIND_DISP,
    SLEM_KIND_NIT,
    SLEM_KIND_UCC,
    SLEM_KIND_NONE
  } slem_kind_t;

  typedef enum logic [1:0] {
    SLEM_BUS_IDLE,
    SLEM_BUS_WRITE,
    SLEM_BUS_RDWAIT,
    SLEM_BUS_RDDATA
  } slem_bus_t;

endpackage

/* hdl/slem_regs.sv */
// AHB-Lite register bank for lane error counter readback and lane deskew.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "slem_map.svh"

module slem_regs #(
  parameter int LANES = 8
) (
  // Clock and reset
  input  wire logic              SYS_CLK_I,
  input  wire logic              ARST_N_I,
  // AHB-Lite slave
  input  wire logic              HSEL_I,
  input  wire logic [31:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic      [31:0]       HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  // Per-lane error counters, lane n in bits [8n+7:8n]
  input  wire logic [LANES*8-1:0] DISP_CNT_I,
  input  wire logic [LANES*8-1:0] NIT_CNT_I,
  input  wire logic [LANES*8-1:0] UCC_CNT_I,
  // Deskew enables and interrupt
  output logic      [LANES-1:0]  LANE_ALIGN_EN_O,
  output logic                   IRQ_O
);

  // ==========================================================================
  // Declarations
  slem_pkg::slem_bus_t  bus_state;
  slem_pkg::slem_kind_t counter_kind_pick;
  logic [2:0]           monitor_lane_pick;
  logic [LANES-1:0]     lane_align_enable;
  logic                 dual_link;
  logic [LANES-1:0]     irq_status;
  logic [LANES-1:0]     irq_enable;
  logic [LANES-1:0]     full_q;
  logic [LANES-1:0]     full_now;
  logic [LANES-1:0]     full_event;
  logic [LANES-1:0]     irq_clear;
  logic [31:0]          wr_addr;
  logic [31:0]          rd_addr;
  logic [7:0]           counter_readback;
  logic [31:0]          next_rdata;
  logic                 take;
  logic                 take_read;
  logic                 wr_errsel;
  logic                 wr_deskew;
  logic [5:0]           lane_base;

  // ==========================================================================
  // Address phase acceptance
  assign take      = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign take_read = take && !HWRITE_I;
  assign wr_errsel = (bus_state == slem_pkg::SLEM_BUS_WRITE) &&
                     (wr_addr == `SLEM_ADDR_ERRSEL);
  assign wr_deskew = (bus_state == slem_pkg::SLEM_BUS_WRITE) &&
                     (wr_addr == `SLEM_ADDR_DESKEW);

  // ==========================================================================
  // Bus state machine
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bus_state <= slem_pkg::SLEM_BUS_IDLE;
    end else begin
      case (bus_state)
        slem_pkg::SLEM_BUS_RDWAIT: begin
          bus_state <= slem_pkg::SLEM_BUS_RDDATA;
        end
        slem_pkg::SLEM_BUS_IDLE,
        slem_pkg::SLEM_BUS_WRITE,
        slem_pkg::SLEM_BUS_RDDATA: begin
          if (take && HWRITE_I) begin
            bus_state <= slem_pkg::SLEM_BUS_WRITE;
          end else if (take_read) begin
            bus_state <= slem_pkg::SLEM_BUS_RDWAIT;
          end else begin
            bus_state <= slem_pkg::SLEM_BUS_IDLE;
          end
        end
        default: begin
          bus_state <= slem_pkg::SLEM_BUS_IDLE;
        end
      endcase
    end
  end

  // Address capture for the data phase.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_addr <= 32'h0;
      rd_addr <= 32'h0;
    end else if (take && bus_state != slem_pkg::SLEM_BUS_RDWAIT) begin
      wr_addr <= HADDR_I;
      rd_addr <= HADDR_I;
    end
  end

  // Reads take one wait state so that a select written just before is seen.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else if (bus_state == slem_pkg::SLEM_BUS_RDWAIT) begin
      HREADYOUT_O <= 1'b1;
    end else if (take_read) begin
      HREADYOUT_O <= 1'b0;
    end
  end

  // ==========================================================================
  // Counter select register
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      monitor_lane_pick <= 3'h0;
      counter_kind_pick <= slem_pkg::SLEM_KIND_DISP;
    end else if (wr_errsel) begin
      monitor_lane_pick <= HWDATA_I[`SLEM_LANE_HI:`SLEM_LANE_LO];
      counter_kind_pick <= slem_pkg::slem_kind_t'(
        HWDATA_I[`SLEM_KIND_HI:`SLEM_KIND_LO]);
    end
  end

  // The readback is a pure mux; counters are untouched by a read.
  assign lane_base = {monitor_lane_pick, 3'h0};
  always_comb begin
    case (counter_kind_pick)
      slem_pkg::SLEM_KIND_DISP: counter_readback = DISP_CNT_I[lane_base +: 8];
      slem_pkg::SLEM_KIND_NIT:  counter_readback = NIT_CNT_I[lane_base +: 8];
      slem_pkg::SLEM_KIND_UCC:  counter_readback = UCC_CNT_I[lane_base +: 8];
      default:                  counter_readback = 8'h0;
    endcase
  end

  // ==========================================================================
  // Deskew enable and mode registers
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lane_align_enable <= LANES'(`SLEM_DESKEW_RST);
    end else if (wr_deskew) begin
      lane_align_enable <= HWDATA_I[LANES-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dual_link <= 1'b0;
    end else if (bus_state == slem_pkg::SLEM_BUS_WRITE &&
                 wr_addr == `SLEM_ADDR_MODE) begin
      dual_link <= HWDATA_I[`SLEM_MODE_DUAL];
    end
  end

  // In dual-link mode each link of four lanes uses the low four enables.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LANE_ALIGN_EN_O <= LANES'(`SLEM_DESKEW_RST);
    end else if (dual_link) begin
      LANE_ALIGN_EN_O <= {2{lane_align_enable[LANES/2-1:0]}};
    end else begin
      LANE_ALIGN_EN_O <= lane_align_enable;
    end
  end

  // ==========================================================================
  // Interrupts: a lane raises an event when any of its counters saturates
  genvar gl;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      assign full_now[gl] = (DISP_CNT_I[gl*8 +: 8] == `SLEM_CNT_FULL) ||
                            (NIT_CNT_I[gl*8 +: 8]  == `SLEM_CNT_FULL) ||
                            (UCC_CNT_I[gl*8 +: 8]  == `SLEM_CNT_FULL);
    end
  endgenerate

  assign full_event = full_now & ~full_q;
  assign irq_clear  = (bus_state == slem_pkg::SLEM_BUS_WRITE &&
                       wr_addr == `SLEM_ADDR_IRQ_CLR) ?
                      HWDATA_I[LANES-1:0] : '0;

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      full_q <= '0;
    end else begin
      full_q <= full_now;
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | full_event;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irq_enable <= '0;
    end else if (bus_state == slem_pkg::SLEM_BUS_WRITE &&
                 wr_addr == `SLEM_ADDR_IRQ_EN) begin
      irq_enable <= HWDATA_I[LANES-1:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    next_rdata = 32'h0;
    case (rd_addr)
      `SLEM_ADDR_ERRSEL:   next_rdata[7:0]       = counter_readback;
      `SLEM_ADDR_DESKEW:   next_rdata[LANES-1:0] = lane_align_enable;
      `SLEM_ADDR_IRQ_STAT: next_rdata[LANES-1:0] = irq_status;
      `SLEM_ADDR_IRQ_EN:   next_rdata[LANES-1:0] = irq_enable;
      `SLEM_ADDR_MODE:     next_rdata[0]         = dual_link;
      default:             next_rdata            = 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      HRDATA_O <= 32'h0;
    end else if (bus_state == slem_pkg::SLEM_BUS_RDWAIT) begin
      HRDATA_O <= next_rdata;
    end
  end

  // ==========================================================================
  // Checks
  logic [7:0] ref_pick;
  logic       errsel_read;

  always_comb begin
    ref_pick = 8'h0;
    for (int k = 0; k < LANES; k++) begin
      if (monitor_lane_pick == k[2:0]) begin
        if (counter_kind_pick == slem_pkg::SLEM_KIND_DISP) begin
          ref_pick = DISP_CNT_I[k*8 +: 8];
        end else if (counter_kind_pick == slem_pkg::SLEM_KIND_NIT) begin
          ref_pick = NIT_CNT_I[k*8 +: 8];
        end else if (counter_kind_pick == slem_pkg::SLEM_KIND_UCC) begin
          ref_pick = UCC_CNT_I[k*8 +: 8];
        end
      end
    end
  end

  assign errsel_read = take_read && HADDR_I == `SLEM_ADDR_ERRSEL &&
                       bus_state != slem_pkg::SLEM_BUS_RDWAIT;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_read_wait;
    !HREADYOUT_O ##1 HREADYOUT_O;
  endsequence

  sequence s_select_write;
    bus_state == slem_pkg::SLEM_BUS_WRITE &&
      wr_addr == `SLEM_ADDR_ERRSEL;
  endsequence

  chk_lane_pick_store: assert property (
    s_select_write |=> monitor_lane_pick == $past(HWDATA_I[6:4]))
    else $error("lane pick not stored from write data");

  chk_kind_pick_store: assert property (
    s_select_write |=> counter_kind_pick == $past(HWDATA_I[1:0]))
    else $error("counter kind pick not stored from write data");

  chk_readback_value: assert property (
    errsel_read |=> s_read_wait ##0 HRDATA_O[7:0] == $past(ref_pick))
    else $error("readback does not match picked counter");

  chk_read_wait_state: assert property (
    take_read && bus_state != slem_pkg::SLEM_BUS_RDWAIT |=> s_read_wait)
    else $error("read did not complete after one wait state");

  chk_deskew_store: assert property (
    bus_state == slem_pkg::SLEM_BUS_WRITE && wr_addr == `SLEM_ADDR_DESKEW
      |=> ##1 LANE_ALIGN_EN_O[0] == ($past(HWDATA_I[0], 2)))
    else $error("deskew enable write did not reach lane 0");

  chk_dual_link_map: assert property (
    dual_link |=> LANE_ALIGN_EN_O[7:4] == $past(lane_align_enable[3:0]))
    else $error("dual link upper lanes do not follow low enables");

  chk_unused_zero: assert property (
    errsel_read |=> ##1 HRDATA_O[31:8] == 24'h0)
    else $error("unused readback bits not zero");

  chk_event_beats_clear: assert property (
    |full_event |=> (irq_status & $past(full_event)) == $past(full_event))
    else $error("saturation event lost against a clear");

endmodule

`default_nettype wire

/* bench/slem_regs_bench.sv */
// Self-checking testbench for the lane error monitor register bank.
`timescale 1ns/10ps
`default_nettype none
`include "slem_map.svh"

module slem_regs_bench;

  typedef struct packed {
    logic [2:0] lane;
    logic [1:0] kind;
    logic [7:0] cnt;
  } slem_row_t;

  logic        clk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [63:0] disp_cnt;
  logic [63:0] nit_cnt;
  logic [63:0] ucc_cnt;
  logic [7:0]  align_en;
  logic        irq;
  logic [31:0] rd;
  int          bad_count;
  int          cmp_count;
  slem_row_t   rows [8];

  // ==========================================================================
  // Design under test
  slem_regs #(.LANES(8)) slem_regs_i (
    .SYS_CLK_I      (clk),
    .ARST_N_I       (arst_n),
    .HSEL_I         (hsel),
    .HADDR_I        (haddr),
    .HTRANS_I       (htrans),
    .HWRITE_I       (hwrite),
    .HSIZE_I        (3'h2),
    .HWDATA_I       (hwdata),
    .HREADY_I       (hreadyout),
    .HRDATA_O       (hrdata),
    .HREADYOUT_O    (hreadyout),
    .HRESP_O        (hresp),
    .DISP_CNT_I     (disp_cnt),
    .NIT_CNT_I      (nit_cnt),
    .UCC_CNT_I      (ucc_cnt),
    .LANE_ALIGN_EN_O(align_en),
    .IRQ_O          (irq)
  );

  always #25 clk = ~clk;

  // ==========================================================================
  // Checking and bus tasks
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Waits for a sampled ready, giving up after a bounded number of edges.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n <= 20) begin
      n++;
      @(posedge clk);
    end
    if (hreadyout !== 1'b1) begin
      bad_count++;
      $display("mismatch hready_wait expected 1 seen %b", hreadyout);
      stop_test();
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] addr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= addr;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    ahb(1'b1, addr, data, unused);
  endtask

  task automatic rdchk(input string name, input logic [31:0] addr,
                       input logic [31:0] exp);
    ahb(1'b0, addr, 32'h0, rd);
    chk(name, exp, rd);
  endtask

  // ==========================================================================
  // Stimulus
  initial begin
    clk      = 1'b0;
    arst_n   = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'h0;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    for (int n = 0; n < 8; n++) begin
      disp_cnt[8*n +: 8] = 8'h10 + 8'(n);
      nit_cnt[8*n +: 8]  = 8'h20 + 8'(n);
      ucc_cnt[8*n +: 8]  = 8'h30 + 8'(n);
    end
    rows = '{'{3'h0, 2'h0, 8'h10}, '{3'h7, 2'h0, 8'h17},
             '{3'h1, 2'h1, 8'h21}, '{3'h6, 2'h1, 8'h26},
             '{3'h2, 2'h2, 8'h32}, '{3'h5, 2'h2, 8'h35},
             '{3'h3, 2'h3, 8'h00}, '{3'h4, 2'h2, 8'h34}};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Table of lane and kind picks, junk in the unused select bits.
    foreach (rows[i]) begin
      wr(`SLEM_ADDR_ERRSEL, {24'hFFFFFF, 1'b1, rows[i].lane, 2'h3,
                             rows[i].kind});
      rdchk("readback", `SLEM_ADDR_ERRSEL, {24'h0, rows[i].cnt});
    end
    // Reset values, then a mid-run reset after changing them.
    chk("align_en_rst", 32'h0F, {24'h0, align_en});
    rdchk("deskew_rst", `SLEM_ADDR_DESKEW, 32'h0F);
    wr(`SLEM_ADDR_DESKEW, 32'hFFFF_FFA5);
    rdchk("deskew_rw", `SLEM_ADDR_DESKEW, 32'hA5);
    repeat (2) @(posedge clk);
    chk("align_en_wr", 32'hA5, {24'h0, align_en});
    wr(`SLEM_ADDR_MODE, 32'h1);
    repeat (2) @(posedge clk);
    chk("align_en_dual", 32'h55, {24'h0, align_en});
    wr(`SLEM_ADDR_DESKEW, 32'h3C);
    repeat (2) @(posedge clk);
    chk("align_en_dual2", 32'hCC, {24'h0, align_en});
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("align_en_rst2", 32'h0F, {24'h0, align_en});
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk("mode_rst", `SLEM_ADDR_MODE, 32'h0);
    rdchk("sel_rst", `SLEM_ADDR_ERRSEL, 32'h10);
    // Back-to-back write then read of the picks.
    wr(`SLEM_ADDR_ERRSEL, 32'h71);
    rdchk("b2b_read", `SLEM_ADDR_ERRSEL, 32'h27);
    // Unmapped place reads zero and ignores writes.
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    rdchk("unmapped", 32'h0000_0100, 32'h0);
    // Interrupt: raise, mask, unmask, clear.
    wr(`SLEM_ADDR_IRQ_EN, 32'h04);
    disp_cnt[23:16] <= 8'hFF;
    repeat (3) @(posedge clk);
    chk("irq_set", 32'h1, {31'h0, irq});
    rdchk("irq_stat", `SLEM_ADDR_IRQ_STAT, 32'h04);
    wr(`SLEM_ADDR_ERRSEL, 32'h20);
    rdchk("readback_full", `SLEM_ADDR_ERRSEL, 32'hFF);
    wr(`SLEM_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(`SLEM_ADDR_IRQ_EN, 32'h04);
    repeat (2) @(posedge clk);
    chk("irq_unmask", 32'h1, {31'h0, irq});
    wr(`SLEM_ADDR_IRQ_CLR, 32'h04);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rdchk("irq_stat_clr", `SLEM_ADDR_IRQ_STAT, 32'h0);
    // Lane 3 saturates in the very cycle that its clear lands: set wins.
    wr(`SLEM_ADDR_IRQ_EN, 32'h08);
    fork
      wr(`SLEM_ADDR_IRQ_CLR, 32'h08);
      begin
        @(posedge clk);
        disp_cnt[31:24] <= 8'hFF;
      end
    join
    repeat (2) @(posedge clk);
    chk("irq_set_wins", 32'h1, {31'h0, irq});
    rdchk("irq_stat_wins", `SLEM_ADDR_IRQ_STAT, 32'h08);
    chk("hresp", 32'h0, {31'h0, hresp});
    stop_test();
  end

endmodule
`default_nettype wire
